// file: dma_sel_pkg.sv
// Purpose: shared constants for the dma request and address select block
// Assumes: 8-bit data, 20-bit physical addresses, 18-bit i/o address field
// Notes: register offsets are indices on the plain register port
package dma_sel_pkg;
   localparam int ADDR_W = 20;
   localparam int IOA_W = 18;
   localparam int CNT_W = 16;
   // register offsets
   localparam logic [3:0] REG_SRC_L = 4'h0;
   localparam logic [3:0] REG_SRC_M = 4'h1;
   localparam logic [3:0] REG_SRC_H = 4'h2;
   localparam logic [3:0] REG_IOA_L = 4'h3;
   localparam logic [3:0] REG_IOA_M = 4'h4;
   localparam logic [3:0] REG_IOA_H = 4'h5;
   localparam logic [3:0] REG_CNT_L = 4'h6;
   localparam logic [3:0] REG_CNT_H = 4'h7;
   localparam logic [3:0] REG_MODE = 4'h8;
   localparam logic [3:0] REG_STAT = 4'h9;
   localparam logic [3:0] REG_FIFO = 4'ha;
   // status register fields
   localparam int ST_EN1 = 7;
   localparam int ST_EN0 = 6;
   localparam int ST_WG1_N = 5;
   localparam int ST_WG0_N = 4;
   localparam int ST_MASTER = 0;
   localparam logic [7:0] STAT_RST = 8'h30;
   // mode register fields
   localparam int MD_MEM2MEM = 0;
   localparam int MD_BURST = 1;
   localparam int MD_LEVEL = 2;
   localparam int MD_DIR_TX = 3;
   localparam logic [7:0] MODE_RST = 8'h00;
   // request source codes in bits 17:16
   localparam logic [1:0] SRC_EXT = 2'b00;
   localparam logic [1:0] SRC_SER0 = 2'b01;
   localparam logic [1:0] SRC_SER1 = 2'b10;
   localparam logic [7:0] IO_HIGH_ZERO = 8'h00;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_W = 8;
endpackage

// file: dma_fifo.sv
// Purpose: data fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: flip-flop storage addressed by index
module dma_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic push;
   logic pop;
   assign in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
   assign out_valid = wp_r != rp_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rp_r[AW-1:0]];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
      end else if (push) begin
         wp_r <= wp_r + 1'b1;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rp_r <= '0;
      end else if (pop) begin
         rp_r <= rp_r + 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end
endmodule // dma_fifo

// file: dma_request_and_address_select.sv
// Purpose: one dma channel 0 engine with request source select
// Assumes: bus handshake is gnt from the core; each bus phase holds until gnt
// Notes: reads fill the fifo, writes drain it
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module dma_request_and_address_select #(
   parameter int DEPTH = dma_sel_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic ext_transfer_request_ch0,
   input wire logic ser0_req,
   input wire logic ser1_req,
   input wire logic nmi,
   input wire logic irq,
   input wire logic bus_gnt,
   output logic bus_req,
   output logic [19:0] bus_addr,
   output logic bus_io,
   output logic bus_we,
   output logic bus_rd,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   output logic ser0_req_clr,
   output logic irq_ack_slot,
   output logic irq_blocked
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10,
      ST_GAP = 2'b11
   } dma_state_t;
   dma_state_t state_r;
   logic [19:0] src_r;
   logic [17:0] ioa_r;
   logic [15:0] cnt_r;
   logic [7:0] mode_r;
   logic [7:0] stat_r;
   logic [7:0] rdata_r;
   logic ext_d_r;
   logic edge_pend_r;
   logic nmi_d_r;
   logic [7:0] wdata_r;
   logic req_now;
   logic src_ok;
   logic run;
   logic nmi_rise;
   logic f_in_ready;
   logic f_out_valid;
   logic [7:0] f_out_data;
   logic f_push;
   logic f_pop;
   logic wr_stat;

   function automatic logic io_is_serial(input logic [17:0] a);
      return (a[17:16] == dma_sel_pkg::SRC_SER0 ||
              a[17:16] == dma_sel_pkg::SRC_SER1);
   endfunction

   // nmi acts on its rising edge only
   assign nmi_rise = nmi && !nmi_d_r;
   assign wr_stat = reg_wr && reg_addr == dma_sel_pkg::REG_STAT;
   assign run = stat_r[dma_sel_pkg::ST_MASTER] &&
                stat_r[dma_sel_pkg::ST_EN0];
   // pick request source from io bits 17:16
   always_comb begin
      case (ioa_r[17:16])
         dma_sel_pkg::SRC_SER0: req_now = ser0_req;
         dma_sel_pkg::SRC_SER1: req_now = ser1_req;
         dma_sel_pkg::SRC_EXT: begin
            if (mode_r[dma_sel_pkg::MD_MEM2MEM]) begin
               req_now = 1'b1;
            end else if (mode_r[dma_sel_pkg::MD_LEVEL]) begin
               req_now = ext_transfer_request_ch0;
            end else begin
               req_now = edge_pend_r;
            end
         end
         default: req_now = 1'b0;
      endcase
   end
   assign src_ok = run && cnt_r != '0 && req_now;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_d_r <= 1'b0;
         nmi_d_r <= 1'b0;
      end else begin
         ext_d_r <= ext_transfer_request_ch0;
         nmi_d_r <= nmi;
      end
   end
   // fresh edge latched; consumed when a transfer starts
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_pend_r <= 1'b0;
      end else if (ext_transfer_request_ch0 && !ext_d_r) begin
         edge_pend_r <= 1'b1;
      end else if (state_r == ST_READ && bus_gnt) begin
         edge_pend_r <= 1'b0;
      end else if (ioa_r[17:16] != dma_sel_pkg::SRC_EXT ||
                   mode_r[dma_sel_pkg::MD_LEVEL]) begin
         // an edge seen while the pin is not the edge source is dropped
         edge_pend_r <= 1'b0;
      end
   end

   // status: master enable, channel enables with write gates
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= dma_sel_pkg::STAT_RST;
      end else begin
         if (wr_stat) begin
            if (!reg_wdata[dma_sel_pkg::ST_WG0_N]) begin
               stat_r[dma_sel_pkg::ST_EN0] <=
                  reg_wdata[dma_sel_pkg::ST_EN0];
            end
            if (!reg_wdata[dma_sel_pkg::ST_WG1_N]) begin
               stat_r[dma_sel_pkg::ST_EN1] <=
                  reg_wdata[dma_sel_pkg::ST_EN1];
            end
            stat_r[dma_sel_pkg::ST_MASTER] <=
               reg_wdata[dma_sel_pkg::ST_MASTER];
         end
         if (nmi_rise) begin
            stat_r[dma_sel_pkg::ST_MASTER] <= 1'b0;
         end
         // last unit done: the channel stops by itself
         if (state_r == ST_WRITE && bus_gnt && cnt_r == 16'h0001) begin
            stat_r[dma_sel_pkg::ST_EN0] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= dma_sel_pkg::MODE_RST;
      end else if (reg_wr && reg_addr == dma_sel_pkg::REG_MODE) begin
         mode_r <= reg_wdata;
      end
   end

   // address/count: loaded as given, no translation applied
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_r <= '0;
         ioa_r <= '0;
         cnt_r <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            dma_sel_pkg::REG_SRC_L: src_r[7:0] <= reg_wdata;
            dma_sel_pkg::REG_SRC_M: src_r[15:8] <= reg_wdata;
            dma_sel_pkg::REG_SRC_H: src_r[19:16] <= reg_wdata[3:0];
            dma_sel_pkg::REG_IOA_L: ioa_r[7:0] <= reg_wdata;
            dma_sel_pkg::REG_IOA_M: ioa_r[15:8] <= reg_wdata;
            dma_sel_pkg::REG_IOA_H: ioa_r[17:16] <= reg_wdata[1:0];
            dma_sel_pkg::REG_CNT_L: cnt_r[7:0] <= reg_wdata;
            dma_sel_pkg::REG_CNT_H: cnt_r[15:8] <= reg_wdata;
            default: cnt_r <= cnt_r;
         endcase
      end else if (state_r == ST_WRITE && bus_gnt) begin
         // only moves while a transfer is on the bus
         src_r <= src_r + 20'h00001;
         cnt_r <= cnt_r - 16'h0001;
      end
   end

   // transfer sequencer; nmi lets the running cycle complete
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (src_ok && f_in_ready) begin
                  state_r <= ST_READ;
               end
            end
            ST_READ: begin
               if (bus_gnt) begin
                  state_r <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (bus_gnt) begin
                  if (!mode_r[dma_sel_pkg::MD_BURST] || nmi_rise ||
                      !run) begin
                     state_r <= ST_GAP;
                  end else if (src_ok && f_in_ready &&
                               cnt_r != 16'h0001) begin
                     // the last unit of the count ends a burst here
                     state_r <= ST_READ;
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_GAP: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   assign f_push = state_r == ST_READ && bus_gnt;
   assign f_pop = state_r == ST_WRITE && bus_gnt && f_out_valid;

   // read data queue between the two bus phases
   dma_fifo #(
      .WIDTH(dma_sel_pkg::FIFO_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(f_push),
      .in_ready(f_in_ready),
      .in_data(bus_rdata),
      .out_valid(f_out_valid),
      .out_ready(f_pop),
      .out_data(f_out_data)
   );

   always_comb begin
      bus_req = state_r == ST_READ || state_r == ST_WRITE;
      bus_rd = state_r == ST_READ;
      bus_we = state_r == ST_WRITE;
      bus_wdata = wdata_r;
      // serial/io side is ioa_r; high byte nonzero goes elsewhere
      if (mode_r[dma_sel_pkg::MD_MEM2MEM]) begin
         bus_io = 1'b0;
         bus_addr = (state_r == ST_READ) == mode_r[dma_sel_pkg::MD_DIR_TX]
                    ? src_r : {2'b00, ioa_r};
      end else begin
         bus_io = (state_r == ST_READ) != mode_r[dma_sel_pkg::MD_DIR_TX];
         bus_addr = bus_io ? {4'h0, ioa_r[15:0]} : src_r;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdata_r <= '0;
      end else if (f_push) begin
         // present the word that the coming write phase will pop
         if (f_out_valid) begin
            wdata_r <= f_out_data;
         end else begin
            wdata_r <= bus_rdata;
         end
      end
   end

   // request cleared only when the receive register itself is read
   assign ser0_req_clr = f_push && bus_io &&
      io_is_serial(ioa_r) && ioa_r[17:16] == dma_sel_pkg::SRC_SER0 &&
      ioa_r[15:8] == dma_sel_pkg::IO_HIGH_ZERO;
   assign irq_blocked = mode_r[dma_sel_pkg::MD_MEM2MEM] &&
      mode_r[dma_sel_pkg::MD_BURST] && state_r != ST_IDLE &&
      state_r != ST_GAP;
   assign irq_ack_slot = irq && state_r == ST_GAP;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            dma_sel_pkg::REG_SRC_L: rdata_r <= src_r[7:0];
            dma_sel_pkg::REG_SRC_M: rdata_r <= src_r[15:8];
            dma_sel_pkg::REG_SRC_H: rdata_r <= {4'h0, src_r[19:16]};
            dma_sel_pkg::REG_IOA_L: rdata_r <= ioa_r[7:0];
            dma_sel_pkg::REG_IOA_M: rdata_r <= ioa_r[15:8];
            dma_sel_pkg::REG_IOA_H: rdata_r <= {6'h00, ioa_r[17:16]};
            dma_sel_pkg::REG_CNT_L: rdata_r <= cnt_r[7:0];
            dma_sel_pkg::REG_CNT_H: rdata_r <= cnt_r[15:8];
            dma_sel_pkg::REG_MODE: rdata_r <= mode_r;
            dma_sel_pkg::REG_STAT: rdata_r <= stat_r;
            dma_sel_pkg::REG_FIFO: rdata_r <= {7'h00, f_out_valid};
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end
   // read data stand one cycle, zero otherwise
   assign reg_rdata = rdata_r;
endmodule // dma_request_and_address_select

// file: dma_sel_properties.sv
// Purpose: port-level assertions for the dma request select block
// Assumes: one clock domain, rst_n asynchronous active low
// Notes: bound to the top module at the foot of this file
module dma_sel_properties #(
   parameter int DEPTH = 32
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic ext_transfer_request_ch0,
   input wire logic ser0_req,
   input wire logic ser1_req,
   input wire logic nmi,
   input wire logic irq,
   input wire logic bus_gnt,
   input wire logic bus_req,
   input wire logic [19:0] bus_addr,
   input wire logic bus_io,
   input wire logic bus_we,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic ser0_req_clr,
   input wire logic irq_ack_slot,
   input wire logic irq_blocked
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   rdata_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   start_read_a: assert property ($rose(bus_req) |-> bus_rd)
      else $error("transfer not opened by a read");
   read_write_a: assert property (bus_rd && bus_gnt |=> bus_we)
      else $error("granted read not followed by write");
   one_dir_a: assert property (!(bus_rd && bus_we))
      else $error("read and write at once");
   rx_clear_a: assert property (ser0_req_clr |->
      bus_rd && bus_addr[15:8] == 8'h00)
      else $error("serial clear off the receive read");
   steal_ack_a: assert property (irq_ack_slot |->
      irq && !bus_req && $past(bus_we && bus_gnt))
      else $error("ack slot not after a write");
   burst_mask_a: assert property (irq_blocked |-> !irq_ack_slot)
      else $error("ack while interrupts blocked");
   nmi_halt_a: assert property ($rose(nmi) |->
      ##2 (!$rose(bus_req)) [*8])
      else $error("transfer started after nmi");
endmodule // dma_sel_properties

bind dma_request_and_address_select dma_sel_properties #(.DEPTH(DEPTH))
   u_dma_sel_properties (.*);

// file: dma_bus_partner.sv
// Purpose: core bus and memory stand-in facing the dma engine
// Assumes: grants only while bus_req is high
// Notes: slow grants every other cycle; idle data bus keeps moving
module dma_bus_partner (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic bus_req,
   input wire logic bus_rd,
   input wire logic [19:0] bus_addr,
   output logic bus_gnt,
   output logic [7:0] bus_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) tog_r <= 1'b0;
      else tog_r <= ~tog_r;
   end
   assign bus_gnt = bus_req && (!slow || tog_r);
   assign bus_rdata = bus_rd ? bus_addr[7:0] ^ 8'h5a : {8{tog_r}};
endmodule // dma_bus_partner

// file: dma_request_and_address_select_tb_top.sv
// Purpose: self-checking bench for the dma request select block
// Assumes: fifo depth 4, bus partner memory
// Notes: counters track granted writes, clears and ack slots
module dma_request_and_address_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] RX_REG = 8'h08; // arbitrary receive address
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ext_transfer_request_ch0 = 1'b0;
   logic ser0_req = 1'b0;
   logic ser1_req = 1'b0;
   logic nmi = 1'b0;
   logic irq = 1'b0;
   logic slow = 1'b0;
   logic [7:0] reg_rdata, bus_wdata, bus_rdata;
   logic [19:0] bus_addr;
   logic bus_gnt, bus_req, bus_io, bus_we, bus_rd;
   logic ser0_req_clr, irq_ack_slot, irq_blocked;
   int errors = 0;
   int checks_done = 0;
   int n_wr = 0;
   int n_clr = 0;
   int n_ack = 0;
   int n_blk = 0;
   always #4 ref_clk = ~ref_clk;
   dma_request_and_address_select #(.DEPTH(4))
      u_dma_request_and_address_select (.*);
   dma_bus_partner u_dma_bus_partner (.ref_clk(ref_clk), .rst_n(rst_n),
      .slow(slow), .bus_req(bus_req), .bus_rd(bus_rd),
      .bus_addr(bus_addr), .bus_gnt(bus_gnt), .bus_rdata(bus_rdata));
   always @(posedge ref_clk) begin
      if (bus_we === 1'b1 && bus_gnt === 1'b1) n_wr <= n_wr + 1;
      if (ser0_req_clr === 1'b1) n_clr <= n_clr + 1;
      if (irq_ack_slot === 1'b1) n_ack <= n_ack + 1;
      if (irq_blocked === 1'b1) n_blk <= n_blk + 1;
   end
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] m,
         input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 check(20'(reg_rdata & m), 20'(e));
   endtask
   task automatic prog(input logic [7:0] md, input logic [17:0] io,
         input logic [7:0] cnt);
      logic [7:0] v [10];
      // source 12340h is handed over already physical; gate0 low
      v = '{8'h40, 8'h23, 8'h01, io[7:0], io[15:8], {6'h00, io[17:16]},
            cnt, 8'h00, md, 8'h41};
      for (int i = 0; i < 10; i++) wr(dma_sel_pkg::REG_SRC_L + 4'(i), v[i]);
   endtask
   task automatic wait_wr(input int b, input int n);
      for (int i = 0; i < 400 && n_wr - b < n; i++) @(posedge ref_clk);
      if (n_wr - b < n) begin
         check(20'(n_wr - b), 20'(n));
         conclude();
      end
   endtask
   task automatic expect_wr(input int b, input int n);
      wait_wr(b, n);
      repeat (30) @(posedge ref_clk);
      check(20'(n_wr - b), 20'(n));
   endtask
   task automatic t_regs;
      rd(dma_sel_pkg::REG_STAT, 8'hff, dma_sel_pkg::STAT_RST);
      rd(dma_sel_pkg::REG_MODE, 8'hff, dma_sel_pkg::MODE_RST);
      rd(4'hf, 8'hff, 8'h00);
      wr(dma_sel_pkg::REG_STAT, 8'h50);
      rd(dma_sel_pkg::REG_STAT, 8'h40, 8'h00);
   endtask
   task automatic t_ext;
      int b;
      b = n_wr;
      prog(8'h0c, 18'h00080, 8'h03);
      ext_transfer_request_ch0 <= 1'b1;
      #1;
      for (int i = 0; i < 50 && bus_rd !== 1'b1; i++) #8;
      check(bus_addr, 20'h12340);
      for (int i = 0; i < 50 && bus_we !== 1'b1; i++) #8;
      check(20'(bus_wdata), 20'h0001a);
      check(bus_addr, 20'h00080);
      check(20'(bus_io), 20'h00001);
      expect_wr(b, 3);
      ext_transfer_request_ch0 <= 1'b0;
      b = n_wr;
      prog(8'h08, 18'h00080, 8'h03);
      ext_transfer_request_ch0 <= 1'b1;
      expect_wr(b, 1);
      ext_transfer_request_ch0 <= 1'b0;
      @(posedge ref_clk);
      ext_transfer_request_ch0 <= 1'b1;
      expect_wr(b, 2);
      b = n_wr;
      prog(8'h0c, 18'h10080, 8'h03);
      expect_wr(b, 0);
      ext_transfer_request_ch0 <= 1'b0;
   endtask
   task automatic t_serial;
      int b;
      int c;
      b = n_wr;
      c = n_clr;
      prog(8'h04, {2'b01, 8'h00, RX_REG}, 8'h02);
      ser0_req <= 1'b1;
      expect_wr(b, 2);
      check(20'(n_clr - c), 20'h2);
      b = n_wr;
      c = n_clr;
      prog(8'h04, {2'b01, 8'h12, RX_REG}, 8'h02);
      expect_wr(b, 2);
      check(20'(n_clr - c), 20'h0);
      ser0_req <= 1'b0;
      b = n_wr;
      prog(8'h04, {2'b10, 8'h00, RX_REG}, 8'h02);
      ser1_req <= 1'b1;
      expect_wr(b, 2);
      ser1_req <= 1'b0;
   endtask
   task automatic t_nmi;
      int b;
      b = n_wr;
      slow <= 1'b1;
      prog(8'h0c, 18'h00080, 8'h20);
      ext_transfer_request_ch0 <= 1'b1;
      wait_wr(b, 4);
      nmi <= 1'b1;
      rd(dma_sel_pkg::REG_STAT, 8'h01, 8'h00);
      // let the cycle in flight finish before counting
      repeat (8) @(posedge ref_clk);
      expect_wr(n_wr, 0);
      nmi <= 1'b0;
      wr(dma_sel_pkg::REG_STAT, 8'h41);
      expect_wr(b, 32);
      ext_transfer_request_ch0 <= 1'b0;
      slow <= 1'b0;
   endtask
   task automatic t_irq;
      int a;
      int k;
      a = n_ack;
      irq <= 1'b1;
      prog(8'h01, 18'h00080, 8'h04);
      expect_wr(n_wr, 4);
      check(20'(n_ack > a), 20'h1);
      a = n_ack;
      k = n_blk;
      prog(8'h03, 18'h00080, 8'h04);
      expect_wr(n_wr, 4);
      check(20'(n_ack - a), 20'h0);
      check(20'(n_blk > k), 20'h1);
      irq <= 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_ext();
      t_serial();
      t_nmi();
      t_irq();
      conclude();
   end
endmodule // dma_request_and_address_select_tb_top
